/* File: core/stpatt_ctrl.sv */
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
// Host side controller for a 7-bit step attenuator control port
module stpatt_ctrl (
	input  wire logic       mclk_i,
	input  wire logic       arst_n_i,
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic [7:0]      reg_rdata_o,
	output logic            sclk_o,
	output logic            sdata_o,
	output logic            load_strobe_o,
	output logic            select_serial_o,
	output logic [6:0]      parallel_setting_pins_o
);
	import stpatt_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_LE_HI, ST_LE_LO}
		stpatt_state_t;

	stpatt_state_t state_q;
	logic [1:0]    mode_q;
	logic [7:0]    atten_q;
	logic [2:0]    addr_q;
	logic          seq_ok_q;
	logic [4:0]    bits_q;
	logic [7:0]    rdata_q;
	logic          sclk_q;
	logic          le_q;
	logic          sel_q;
	logic [6:0]    pins_q;
	logic [3:0]    wait_q;

	// Register decode
	wire wr_ctrl  = reg_wr_i && (reg_addr_i == REG_CTRL);
	wire wr_atten = reg_wr_i && (reg_addr_i == REG_ATTEN);
	wire wr_addr  = reg_wr_i && (reg_addr_i == REG_ADDR);
	wire wr_cmd   = reg_wr_i && (reg_addr_i == REG_CMD) && reg_wdata_i[CMD_GO];
	wire idle     = (state_q == ST_IDLE);
	wire go       = wr_cmd && idle;

	// Mode in force, decoded as serial and direct
	wire       is_serial  = (mode_q == MODE_SERIAL);
	wire       is_direct  = (mode_q == MODE_DIRECT);
	// Serial writes always clear the top bit: word is dB times four
	wire [7:0] ser_atten  = {1'b0, atten_q[SET_BITS-1:0]};
	wire [15:0] frame     = {5'h00, addr_q, ser_atten};
	// Pins low in serial mode, until the first serial write completes, and for one
	// cycle after select falls so that select always leads the pins
	wire       pins_force = is_serial || sel_q || !seq_ok_q;
	wire [6:0] pins_d     = pins_force ? 7'h00 : atten_q[SET_BITS-1:0];

	logic tick;
	logic bit_now;
	logic step;

	stpatt_tick #(.COUNT(HALF_CYC)) u_tick (
		.mclk_i  (mclk_i),
		.arst_n_i(arst_n_i),
		.run_i   (!idle),
		.tick_o  (tick)
	);

	assign step = tick && (state_q == ST_HIGH);

	stpatt_shift u_shift (
		.mclk_i  (mclk_i),
		.arst_n_i(arst_n_i),
		.load_i  (go && is_serial),
		.frame_i (frame),
		.step_i  (step),
		.bit_o   (bit_now)
	);

	// Software registers; parallel mode is blocked until the first serial write,
	// and the mode holds still while a transfer runs so select cannot move mid-frame
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			mode_q  <= MODE_SERIAL;
			atten_q <= ATTEN_RST;
			addr_q  <= ADDR_RST;
		end
		else
		begin
			if (wr_ctrl && idle && (seq_ok_q || reg_wdata_i[1:0] == MODE_SERIAL))
				mode_q <= reg_wdata_i[CTRL_MODE_HI:CTRL_MODE_LO];
			if (wr_atten)
				atten_q <= reg_wdata_i;
			if (wr_addr)
				addr_q <= reg_wdata_i[2:0];
		end
	end

	// Sequence done flag: set once, never cleared until reset
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			seq_ok_q <= 1'b0;
		else if (state_q == ST_LE_LO && tick && sel_q)
			seq_ok_q <= 1'b1;
	end

	// Transfer sequencer; latched parallel skips the shift states
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_q <= ST_IDLE;
			bits_q  <= '0;
			wait_q  <= '0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					if (go && !is_direct)
					begin
						state_q <= ST_SETUP;
						bits_q  <= 5'(FRAME_BITS);
						wait_q  <= 4'(SETUP_CYC);
					end
				ST_SETUP:
					if (wait_q > 4'h1)
						wait_q <= wait_q - 4'h1;
					else
						state_q <= sel_q ? ST_LOW : ST_LE_HI;
				ST_LOW:
					if (tick)
						state_q <= ST_HIGH;
				ST_HIGH:
					if (tick)
					begin
						bits_q  <= bits_q - 5'h01;
						state_q <= (bits_q == 5'h01) ? ST_LE_HI : ST_LOW;
					end
				ST_LE_HI:
					if (tick)
						state_q <= ST_LE_LO;
				ST_LE_LO:
					if (tick)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Pin drivers, all registered; pins and select move only between transfers,
	// and the direct strobe waits for select to fall so no stray capture occurs
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sclk_q <= 1'b0;
			le_q   <= 1'b0;
			sel_q  <= 1'b1;
			pins_q <= 7'h00;
		end
		else
		begin
			sclk_q <= (state_q == ST_HIGH);
			le_q   <= (is_direct && !sel_q) || (state_q == ST_LE_HI);
			if (idle)
			begin
				pins_q <= pins_d;
				sel_q  <= is_serial;
			end
		end
	end

	// Read port, one cycle latency; unmapped reads zero
	wire [7:0] status = {5'h00, sel_q, seq_ok_q, !idle};
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_q <= 8'h00;
		else if (!reg_rd_i)
			rdata_q <= 8'h00;
		else
		begin
			case (reg_addr_i)
				REG_CTRL:   rdata_q <= {6'h00, mode_q};
				REG_ATTEN:  rdata_q <= atten_q;
				REG_ADDR:   rdata_q <= {5'h00, addr_q};
				REG_STATUS: rdata_q <= status;
				default:    rdata_q <= 8'h00;
			endcase
		end
	end

	logic sdata_q;
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sdata_q <= 1'b0;
		else
			sdata_q <= (state_q == ST_LOW || state_q == ST_HIGH) ? bit_now : 1'b0;
	end

	assign reg_rdata_o             = rdata_q;
	assign sclk_o                  = sclk_q;
	assign sdata_o                 = sdata_q;
	assign load_strobe_o           = le_q;
	assign select_serial_o         = sel_q;
	assign parallel_setting_pins_o = pins_q;

	// Rising serial clock edges of the frame in flight, for the pin-level checks
	wire        sclk_rise = (state_q == ST_HIGH) && !sclk_q;
	logic [4:0] edges_q;
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			edges_q <= '0;
		else if (idle)
			edges_q <= '0;
		else if (sclk_rise)
			edges_q <= edges_q + 5'h01;
	end

	// Strobe stays low while the serial clock runs
	a_strobe_low_shift: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		sclk_q |-> !le_q)
		else $error("strobe high during shift");

	// Pins held low whenever serial select is driven
	a_pins_low_serial: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		sel_q |-> (pins_q == 7'h00))
		else $error("pins not low");

	// Parallel selection only after the first serial write
	a_parallel_after_seq: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		$fell(sel_q) |-> seq_ok_q)
		else $error("parallel before serial write");

	// Sixteen rising serial clock edges per frame before the strobe
	a_frame_len: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		($rose(le_q) && sel_q) |-> (edges_q == 5'(FRAME_BITS)))
		else $error("frame length wrong");

	// Direct mode holds the strobe high
	a_direct_high: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		(is_direct && $stable(mode_q)) |=> le_q)
		else $error("direct strobe low");

	// Strobe pulse returns low within eight cycles, four half periods
	a_strobe_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		($rose(le_q) && !is_direct) |-> ##[1:8] !le_q)
		else $error("strobe stuck");

	// The eighth bit on the data pin is the top attenuation bit, always low
	a_top_bit_zero: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		(sclk_rise && edges_q == 5'h07) |-> !sdata_q)
		else $error("top bit set");

	// Address byte upper bits leave the data pin as zero
	a_addr_upper: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		(sclk_rise && edges_q > 5'h0a) |-> !sdata_q)
		else $error("address upper bits set");

	// Data holds across the serial clock rising edge
	a_data_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		sclk_rise |=> $stable(sdata_q))
		else $error("data moved at clock rise");

	// Select moves only between transfers
	a_sel_idle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		$changed(sel_q) |-> $past(idle))
		else $error("select moved mid transfer");

	// Pins move only between transfers, never under a strobe pulse
	a_pins_idle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		$changed(pins_q) |-> $past(idle))
		else $error("pins moved mid transfer");

	// Serial mode is kept until the first serial frame has gone out
	a_mode_locked: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		!seq_ok_q |-> (mode_q == MODE_SERIAL))
		else $error("mode left serial too early");

	// Once the sequence is done it stays done
	a_seq_sticky: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		seq_ok_q |=> seq_ok_q)
		else $error("sequence flag dropped");

	// Serial clock rests low outside a transfer
	a_clk_idle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		idle |-> !sclk_q)
		else $error("serial clock high while idle");

	// A start in direct mode leaves the sequencer idle
	a_go_direct: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		(go && is_direct) |=> idle)
		else $error("transfer started in direct mode");

	// Every transfer ends within a bounded time
	a_busy_bound: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		$fell(idle) |-> ##[1:100] idle)
		else $error("transfer did not end");

	// Outside direct mode an idle controller keeps the strobe low
	a_latched_low: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		(idle && !is_direct) |=> !le_q)
		else $error("strobe high while idle");
endmodule : stpatt_ctrl

/* File: core/stpatt_shift.sv */
`timescale 1ns/10ps
// Frame shifter: presents the low bit, drops it after each rising edge
module stpatt_shift (
	input  wire logic        mclk_i,
	input  wire logic        arst_n_i,
	input  wire logic        load_i,
	input  wire logic [15:0] frame_i,
	input  wire logic        step_i,
	output logic             bit_o
);
	import stpatt_pkg::*;
	logic [15:0] sh_q;

	// LSB leaves first so the attenuation byte precedes the address byte
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sh_q <= '0;
		else if (load_i)
			sh_q <= frame_i;
		else if (step_i)
			sh_q <= {1'b0, sh_q[15:1]};
	end

	assign bit_o = sh_q[0];
endmodule : stpatt_shift

/* File: core/stpatt_tick.sv */
`timescale 1ns/10ps
// Free counter giving one pulse every COUNT cycles while enabled
module stpatt_tick #(
	parameter int COUNT = 2
) (
	input  wire logic mclk_i,
	input  wire logic arst_n_i,
	input  wire logic run_i,
	output logic      tick_o
);
	import stpatt_pkg::*;
	localparam int W = $clog2(COUNT + 1);
	logic [W-1:0] cnt_q;
	wire          last = (cnt_q == W'(COUNT - 1));

	// Restart on every idle so the first tick comes COUNT cycles after leaving idle
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cnt_q <= '0;
		else if (!run_i || last)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + W'(1);
	end

	assign tick_o = run_i && last;
endmodule : stpatt_tick

/* File: pkg/stpatt_pkg.sv */
package stpatt_pkg;
	// Software register indices
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ATTEN  = 4'h1;
	localparam logic [3:0] REG_ADDR   = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_CMD    = 4'h4;
	// Control register field positions
	localparam int CTRL_MODE_LO = 0;
	localparam int CTRL_MODE_HI = 1;
	// Command register bits
	localparam int CMD_GO = 0;
	// Status bit positions
	localparam int ST_BUSY   = 0;
	localparam int ST_SEQOK  = 1;
	localparam int ST_SERIAL = 2;
	// Mode codes written by software
	localparam logic [1:0] MODE_SERIAL  = 2'h0;
	localparam logic [1:0] MODE_LATCHED = 2'h1;
	localparam logic [1:0] MODE_DIRECT  = 2'h2;
	// Frame layout
	localparam int FRAME_BITS = 16;
	localparam int WORD_BITS  = 8;
	localparam int SET_BITS   = 7;
	// Reset values
	localparam logic [7:0] ATTEN_RST = 8'h7f;
	localparam logic [2:0] ADDR_RST  = 3'h0;
	// Link timing: half period of the serial clock and setup time
	localparam int CLK_MHZ      = 25;
	localparam int HALF_NS      = 60;
	localparam int HALF_CYC     = (HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_NS     = 120;
	localparam int SETUP_CYC    = (SETUP_NS * CLK_MHZ + 999) / 1000;
endpackage : stpatt_pkg

/* File: tb/stpatt_ctrl_tb.sv */
`timescale 1ns/10ps
module stpatt_ctrl_tb;
	import stpatt_pkg::*;
	logic       mclk_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic       reg_wr_i = 1'b0;
	logic       reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o, atten, v;
	logic       sclk_o, sdata_o, load_strobe_o, select_serial_o;
	logic [6:0] pins;
	int         miscompares = 0;
	int         n_compared = 0;
	// Free running system clock
	always #20 mclk_i = ~mclk_i;
	stpatt_ctrl DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .sclk_o(sclk_o), .sdata_o(sdata_o),
		.load_strobe_o(load_strobe_o), .select_serial_o(select_serial_o),
		.parallel_setting_pins_o(pins));
	stpatt_dev_model #(.STRAP(3'h5)) dev (.sclk_i(sclk_o), .sdata_i(sdata_o),
		.load_strobe_i(load_strobe_o), .select_serial_i(select_serial_o),
		.parallel_setting_pins_i(pins), .atten_o(atten));
	task tally_and_finish();
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// Read data is taken in the cycle after the strobe, once it has settled
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	// Start a transfer and poll busy under a bounded count
	task go();
		int n;
		wr(REG_CMD, 8'h01);
		for (n = 0; n < 100; n++)
		begin
			rd(REG_STATUS, v);
			if (v[ST_BUSY] === 1'b0)
				break;
		end
		if (n == 100)
			miscompares++;
		repeat (4) @(posedge mclk_i);
	endtask : go
	// Hang guard: far longer than the whole sequence needs
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		repeat (8) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		rd(REG_STATUS, v);
		chk("status", v & 8'h07, 8'h04);
		chk("core", atten, ATTEN_RST);
		rd(REG_ATTEN, v);
		chk("atten reg", v, ATTEN_RST);
		wr(REG_CTRL, {6'h00, MODE_LATCHED});
		rd(REG_CTRL, v);
		chk("mode refused", v & 8'h03, {6'h00, MODE_SERIAL});
		wr(REG_ADDR, 8'hfd);
		rd(REG_ADDR, v);
		chk("addr reg", v, 8'h05);
		wr(REG_ATTEN, 8'hc9);
		wr(4'hf, 8'h00);
		go();
		chk("serial pins", {1'b0, pins}, 8'h00);
		chk("core", atten, 8'h49);
		wr(REG_ADDR, 8'h02);
		wr(REG_ATTEN, 8'h11);
		go();
		chk("no match", atten, 8'h49);
		rd(REG_STATUS, v);
		chk("seq done", v & 8'h07, 8'h06);
		wr(REG_CTRL, {6'h00, MODE_LATCHED});
		wr(REG_ATTEN, 8'h2a);
		repeat (4) @(posedge mclk_i);
		chk("held", atten, 8'h49);
		chk("pins", {1'b0, pins}, 8'h2a);
		chk("select", {7'h00, select_serial_o}, 8'h00);
		go();
		chk("latched", atten, 8'h2a);
		wr(REG_CTRL, {6'h00, MODE_DIRECT});
		wr(REG_ATTEN, 8'h95);
		repeat (4) @(posedge mclk_i);
		chk("direct", atten, 8'h15);
		wr(REG_CMD, 8'h01);
		rd(REG_STATUS, v);
		chk("direct go", v & 8'h07, 8'h02);
		wr(REG_CTRL, {6'h00, MODE_SERIAL});
		wr(REG_ADDR, 8'h05);
		wr(REG_ATTEN, 8'h7e);
		go();
		chk("back serial", atten, 8'h7e);
		tally_and_finish();
	end
endmodule : stpatt_ctrl_tb

/* File: tb/stpatt_dev_model.sv */
`timescale 1ns/10ps
// Behavioural attenuator control port standing on the far side of the controller
module stpatt_dev_model #(
	parameter logic [2:0] STRAP = 3'h5
) (
	input  wire logic       sclk_i,
	input  wire logic       sdata_i,
	input  wire logic       load_strobe_i,
	input  wire logic       select_serial_i,
	input  wire logic [6:0] parallel_setting_pins_i,
	output logic [7:0]      atten_o
);
	// Power-up delay of a part that starts in direct mode
	localparam realtime PUP_NS = 400000.0;
	logic [15:0] sr_q;
	logic [7:0]  core_q = 8'h7f;
	logic        pup_direct = 1'b0;
	logic        pup_busy = 1'b1;
	wire  [6:0]  pins_v;
	wire         hit = (sr_q[10:8] == STRAP);
	// A floating or unknown setting pin reads low, the minimum attenuation state
	genvar i;
	for (i = 0; i < 7; i = i + 1)
	begin : g_pin
		assign pins_v[i] = (parallel_setting_pins_i[i] === 1'b1);
	end
	// A part powered up in direct mode sits at maximum until the delay ends
	initial
	begin
		wait (select_serial_i !== 1'bx);
		pup_direct = !select_serial_i && (load_strobe_i === 1'b1);
	end
	initial
		#(PUP_NS) pup_busy = 1'b0;
	// Shift only while strobe is low, so the first bit sent ends at the bottom
	always @(posedge sclk_i)
		if (!load_strobe_i)
			sr_q <= {sdata_i, sr_q[15:1]};
	// Strobe rise loads the core; a foreign address leaves it untouched
	always @(posedge load_strobe_i)
		if (!select_serial_i)
			core_q <= {1'b0, pins_v};
		else if (hit)
			core_q <= sr_q[7:0];
	// Direct mode follows the pins with no capture pulse
	assign atten_o = (!select_serial_i && load_strobe_i)
		? ((pup_direct && pup_busy) ? 8'h7f : {1'b0, pins_v})
		: core_q;
endmodule : stpatt_dev_model
